// File: rtl/uls_break_det.v
`timescale 1ns/1ps
module uls_break_det #(
  parameter FRAME_CYCLES = 1000,
  parameter CW           = 16
) (
  // Clock and reset
  input  wire hclk,
  input  wire hresetn,
  // Serial line
  input  wire rx_line,
  // One pulse per continuous break
  output reg  brk_pulse
);

  reg [CW-1:0] low_cnt_r;
  reg          armed_r;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      low_cnt_r <= {CW{1'b0}};
      armed_r   <= 1'b1;
      brk_pulse <= 1'b0;
    end
    else
    begin
      brk_pulse <= 1'b0;
      if (rx_line)
      begin
        low_cnt_r <= {CW{1'b0}};
        armed_r   <= 1'b1;
      end
      else if (armed_r)
      begin
        // Low for a whole frame, start through stop positions
        if (low_cnt_r == FRAME_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
        begin
          brk_pulse <= 1'b1;
          armed_r   <= 1'b0;
        end
        else
          low_cnt_r <= low_cnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // uls_break_det

// File: rtl/uls_defines.vh
`ifndef ULS_DEFINES_VH
`define ULS_DEFINES_VH

// Register byte offsets
`define ULS_OFS_DATA      8'h00
`define ULS_OFS_CTRL      8'h04
`define ULS_OFS_LSTAT     8'h08
`define ULS_OFS_ISTAT     8'h0c
`define ULS_OFS_IMASK     8'h10

// line_status bit positions
`define ULS_LS_DR         0
`define ULS_LS_OE         1
`define ULS_LS_PE         2
`define ULS_LS_FE         3
`define ULS_LS_BI         4
`define ULS_LS_THRE       5
`define ULS_LS_TEMT       6
`define ULS_LS_FERR       7

// Control bit positions
`define ULS_CTRL_FIFO_EN  0

// Interrupt status and mask bit positions
`define ULS_IRQ_THRE      0
`define ULS_IRQ_RXDATA    1
`define ULS_IRQ_LINE      2
`define ULS_IRQ_W         3

// Receive entry layout: {break, framing, parity, data}
`define ULS_RXE_PE        8
`define ULS_RXE_FE        9
`define ULS_RXE_BI        10
`define ULS_RXE_W         11

// Reset values
`define ULS_RST_CTRL      1'b0
`define ULS_RST_IMASK     3'h0
`define ULS_RST_ISTAT     3'h0

// Break detector default frame time in cycles
`define ULS_FRAME_CYCLES  1000

`endif

// File: rtl/uls_fifo.v
`timescale 1ns/1ps
module uls_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // Control
  input  wire             flush,
  input  wire [AW:0]      cap,
  // Write side
  input  wire             push,
  input  wire [WIDTH-1:0] push_data,
  // Read side
  input  wire             pop,
  output wire [WIDTH-1:0] head,
  output wire [AW:0]      count,
  output wire             full,
  output wire             empty
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            do_push;
  wire            do_pop;

  assign count   = cnt_r;
  assign empty   = (cnt_r == {(AW+1){1'b0}});
  // Capacity shrinks to one entry in character mode
  assign full    = (cnt_r >= cap);
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  assign head    = mem[rp_r];

  always @(posedge hclk)
  begin
    if (do_push)
      mem[wp_r] <= push_data;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      if (do_pop)
        rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      if (do_push & ~do_pop)
        cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      else if (do_pop & ~do_push)
        cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // uls_fifo

// File: rtl/uls_line_status.v
// How it works
// - FIFO mode: bit 7 sets while any stored receive character carries an error.
// - Reading line_status clears bit 7 once no erroneous entry remains queued.
// - Character mode: bit 6 is 1 when holding and shift stages are empty.
// - Bit 6 is 0 while holding stage or shift register holds a character.
// - FIFO mode: bit 6 is 1 only when transmit FIFO and shifter are empty.
// - Character mode: bit 5 sets when the character moves to the shifter.
// - A host write to the holding register clears bit 5.
// - Bit 5 set with its interrupt enabled raises the interrupt.
// - FIFO mode: bit 5 sets when FIFO empties, clears after a write.
// - Break flag sets after the line stays low for a full frame.
// - One continuous break loads a single break character.
// - Framing flag sets for a character without a valid stop bit.
// - Framing status travels with its character, shown at the read head.
// - Framing, break and FIFO error flags are 0 after reset.
// - Parity flag shows the parity error of the head character.
// - Overrun sets when a character arrives while full; stored data kept.
// - Data-ready is 1 while any received character waits.
`timescale 1ns/1ps
`include "uls_defines.vh"
module uls_line_status #(
  parameter DEPTH        = 16,
  parameter AW           = 4,
  parameter FRAME_CYCLES = `ULS_FRAME_CYCLES
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Receiver side
  input  wire        rx_line,
  input  wire        rx_char_valid,
  input  wire [7:0]  rx_char_data,
  input  wire        rx_parity_err,
  input  wire        rx_framing_err,
  // Transmitter side
  input  wire        tx_shift_busy,
  output reg         tx_load,
  output reg  [7:0]  tx_data,
  // Interrupt
  output reg         irq
);

  function [7:0] low_addr;
    input [31:0] a;
    begin
      low_addr = {a[7:2], 2'b00};
    end
  endfunction

  reg [7:0]             addr_r;
  reg                   wr_r;
  reg                   fifo_en_r;
  reg [`ULS_IRQ_W-1:0]  imask_r;
  reg [`ULS_IRQ_W-1:0]  istat_r;
  reg [`ULS_IRQ_W-1:0]  istat_nxt;
  reg                   fifo_err_r;
  reg                   overrun_r;
  reg [AW:0]            err_cnt_r;
  reg [31:0]            rdata_nxt;
  reg [7:0]             line_status;

  wire                  a_ok;
  wire                  a_rd;
  wire [7:0]            a_addr;
  wire                  rd_ls;
  wire                  rd_is;
  wire                  rd_data;
  wire                  wr_data;
  wire                  wr_ctrl;
  wire                  flush;
  wire [AW:0]           cap;
  wire                  brk_pulse;
  wire                  rx_push;
  wire [`ULS_RXE_W-1:0] rx_entry;
  wire [`ULS_RXE_W-1:0] rx_head;
  wire [AW:0]           rx_count;
  wire                  rx_full;
  wire                  rx_empty;
  wire                  rx_pop;
  wire                  push_err;
  wire                  pop_err;
  wire [7:0]            tx_head;
  wire                  tx_full;
  wire                  tx_empty;
  wire                  tx_start;
  wire                  thre;
  wire                  temt;

  // Address phase decode
  assign a_ok    = hsel & htrans[1] & hready;
  assign a_rd    = a_ok & ~hwrite;
  assign a_addr  = low_addr(haddr);
  assign rd_ls   = a_rd & (a_addr == `ULS_OFS_LSTAT);
  assign rd_is   = a_rd & (a_addr == `ULS_OFS_ISTAT);
  assign rd_data = a_rd & (a_addr == `ULS_OFS_DATA);

  // Data phase writes
  assign wr_data = wr_r & (addr_r == `ULS_OFS_DATA);
  assign wr_ctrl = wr_r & (addr_r == `ULS_OFS_CTRL);

  // Changing mode empties both queues, so depths never disagree
  assign flush = wr_ctrl & (hwdata[`ULS_CTRL_FIFO_EN] != fifo_en_r);
  assign cap   = fifo_en_r ? DEPTH[AW:0] : {{AW{1'b0}}, 1'b1};

  uls_break_det #(
    .FRAME_CYCLES (FRAME_CYCLES),
    .CW           (16)
  ) u_brk (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .rx_line   (rx_line),
    .brk_pulse (brk_pulse)
  );

  // Break wins over a character finishing in the same cycle
  assign rx_push  = brk_pulse | rx_char_valid;
  assign rx_entry = brk_pulse ? {1'b1, 1'b1, 1'b0, 8'h00}
                  : {1'b0, rx_framing_err, rx_parity_err, rx_char_data};
  assign rx_pop   = rd_data & ~rx_empty;
  assign push_err = rx_push & ~rx_full
                  & (|rx_entry[`ULS_RXE_BI:`ULS_RXE_PE]);
  assign pop_err  = rx_pop & (|rx_head[`ULS_RXE_BI:`ULS_RXE_PE]);

  uls_fifo #(
    .WIDTH (`ULS_RXE_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_rxq (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .flush     (flush),
    .cap       (cap),
    .push      (rx_push),
    .push_data (rx_entry),
    .pop       (rx_pop),
    .head      (rx_head),
    .count     (rx_count),
    .full      (rx_full),
    .empty     (rx_empty)
  );

  uls_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_txq (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .flush     (flush),
    .cap       (cap),
    .push      (wr_data),
    .push_data (hwdata[7:0]),
    .pop       (tx_start),
    .head      (tx_head),
    .count     (),
    .full      (tx_full),
    .empty     (tx_empty)
  );

  // Hand the next character over once the shifter is idle
  assign tx_start = ~tx_load & ~tx_shift_busy & ~tx_empty;
  assign thre     = tx_empty;
  assign temt     = tx_empty & ~tx_shift_busy & ~tx_load;

  always @*
  begin
    line_status                 = 8'h00;
    line_status[`ULS_LS_DR]     = ~rx_empty;
    line_status[`ULS_LS_OE]     = overrun_r;
    line_status[`ULS_LS_PE]     = ~rx_empty & rx_head[`ULS_RXE_PE];
    line_status[`ULS_LS_FE]     = ~rx_empty & rx_head[`ULS_RXE_FE];
    line_status[`ULS_LS_BI]     = ~rx_empty & rx_head[`ULS_RXE_BI];
    line_status[`ULS_LS_THRE]   = thre;
    line_status[`ULS_LS_TEMT]   = temt;
    line_status[`ULS_LS_FERR]   = fifo_err_r;
  end

  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    case (a_addr)
      `ULS_OFS_DATA:  rdata_nxt[7:0] = rx_empty ? 8'h00 : rx_head[7:0];
      `ULS_OFS_CTRL:  rdata_nxt[`ULS_CTRL_FIFO_EN] = fifo_en_r;
      `ULS_OFS_LSTAT: rdata_nxt[7:0] = line_status;
      `ULS_OFS_ISTAT: rdata_nxt[`ULS_IRQ_W-1:0] = istat_r;
      `ULS_OFS_IMASK: rdata_nxt[`ULS_IRQ_W-1:0] = imask_r;
      default:        rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Sticky events; a set in the clearing cycle survives
  always @*
  begin
    istat_nxt = rd_is ? {`ULS_IRQ_W{1'b0}} : istat_r;
    if (thre)
      istat_nxt[`ULS_IRQ_THRE] = 1'b1;
    if (rx_push & ~rx_full)
      istat_nxt[`ULS_IRQ_RXDATA] = 1'b1;
    if (push_err | (rx_push & rx_full))
      istat_nxt[`ULS_IRQ_LINE] = 1'b1;
  end

  // Bus side; zero wait states, response always OKAY
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r    <= 8'h00;
      wr_r      <= 1'b0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      addr_r <= a_addr;
      wr_r   <= a_ok & hwrite;
      hrdata <= a_rd ? rdata_nxt : 32'h0000_0000;
    end
  end

  // Control and mask registers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fifo_en_r <= `ULS_RST_CTRL;
      imask_r   <= `ULS_RST_IMASK;
    end
    else
    begin
      // Status offset is not decoded for writes
      if (wr_ctrl)
        fifo_en_r <= hwdata[`ULS_CTRL_FIFO_EN];
      if (wr_r & (addr_r == `ULS_OFS_IMASK))
        imask_r <= hwdata[`ULS_IRQ_W-1:0];
    end
  end

  // Hand-over to the shifter
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_load <= 1'b0;
      tx_data <= 8'h00;
    end
    else
    begin
      tx_load <= tx_start;
      if (tx_start)
        tx_data <= tx_head;
    end
  end

  // Interrupt status and request
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      istat_r <= `ULS_RST_ISTAT;
      irq     <= 1'b0;
    end
    else
    begin
      istat_r <= istat_nxt;
      irq     <= |(istat_nxt & imask_r);
    end
  end

  // Receive error tracking
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fifo_err_r <= 1'b0;
      overrun_r  <= 1'b0;
      err_cnt_r  <= {(AW+1){1'b0}};
    end
    else
    begin
      // Count of erroneous entries held in the queue
      if (flush)
        err_cnt_r <= {(AW+1){1'b0}};
      else if (push_err & ~pop_err)
        err_cnt_r <= err_cnt_r + {{AW{1'b0}}, 1'b1};
      else if (pop_err & ~push_err)
        err_cnt_r <= err_cnt_r - {{AW{1'b0}}, 1'b1};
      fifo_err_r <= (fifo_en_r & (err_cnt_r != {(AW+1){1'b0}}))
                  | (fifo_err_r & ~rd_ls);
      // Overflowing character is dropped, queue untouched
      overrun_r <= (rx_push & rx_full) | (overrun_r & ~rd_ls);
    end
  end

endmodule // uls_line_status

// File: test/test_uls_line_status.sv
`timescale 1ns/1ps
`include "uls_defines.vh"
module test_uls_line_status;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rv;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        rx_line = 1, rx_char_valid = 0, rx_pe = 0, rx_fe = 0;
  logic [7:0]  rx_d = 0;
  wire  [31:0] hrdata;
  wire  [7:0]  tx_data;
  wire         hreadyout, hresp, tx_load, irq, busy;
  integer      err_total = 0, samples_checked = 0, i;
  logic [9:0]  rows [4] = '{10'h061, 10'h265, 10'h169, 10'h36d};
  always #5 hclk = ~hclk;
  uls_line_status #(.FRAME_CYCLES(8)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_line(rx_line), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_d), .rx_parity_err(rx_pe), .rx_framing_err(rx_fe),
    .tx_shift_busy(busy), .tx_load(tx_load), .tx_data(tx_data), .irq(irq));
  uls_tx_shifter i_shift (.hclk(hclk), .hresetn(hresetn),
    .tx_load(tx_load), .tx_shift_busy(busy));
  task chk(input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task xfer(input [7:0] a, input w, input [31:0] d);
    hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    rv = hrdata;
  endtask
  task rxc(input [7:0] d, input pe, input fe);
    rx_char_valid <= 1; rx_d <= d; rx_pe <= pe; rx_fe <= fe;
    @(posedge hclk);
    rx_char_valid <= 0;
    @(posedge hclk);
  endtask
  task finish_test;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_total++;
    finish_test;
  end
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    chk(irq, 0);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'h60);
    xfer(`ULS_OFS_LSTAT, 1, 32'hff); xfer(`ULS_OFS_LSTAT, 0, 0);
    chk(rv, 32'h60);
    xfer(8'h1c, 0, 0); chk(rv, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      rxc(8'ha0 + i, rows[i][9], rows[i][8]);
      xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, rows[i][7:0]);
      xfer(`ULS_OFS_DATA, 0, 0); chk(rv, 8'ha0 + i);
      xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'h60);
    end
    // Depth one: the second character overruns
    rxc(8'h11, 0, 0); rxc(8'h22, 0, 0);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'h63);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'h61);
    xfer(`ULS_OFS_DATA, 0, 0); chk(rv, 32'h11);
    xfer(`ULS_OFS_ISTAT, 0, 0); xfer(`ULS_OFS_IMASK, 1, 32'h2);
    repeat (2) @(posedge hclk); chk(irq, 0);
    rxc(8'h33, 0, 0); repeat (2) @(posedge hclk); chk(irq, 1);
    xfer(`ULS_OFS_ISTAT, 0, 0); repeat (2) @(posedge hclk); chk(irq, 0);
    xfer(`ULS_OFS_DATA, 0, 0);
    xfer(`ULS_OFS_IMASK, 1, 32'h1);
    repeat (2) @(posedge hclk); chk(irq, 1);
    xfer(`ULS_OFS_IMASK, 1, 32'h0);
    repeat (2) @(posedge hclk); chk(irq, 0);
    xfer(`ULS_OFS_DATA, 1, 32'h5a);
    i = 0;
    while (!tx_load && i < 20) begin @(posedge hclk); i++; end
    chk(tx_data, 8'h5a);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv[6], 0);
    repeat (30) @(posedge hclk);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'h60);
    // FIFO mode from here until the mid-run reset
    xfer(`ULS_OFS_CTRL, 1, 32'h1);
    xfer(`ULS_OFS_DATA, 1, 32'h01); xfer(`ULS_OFS_DATA, 1, 32'h02);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'h0);
    repeat (60) @(posedge hclk);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'h60);
    rxc(8'h44, 1, 0); rxc(8'h55, 0, 0);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'he5);
    xfer(`ULS_OFS_DATA, 0, 0); chk(rv, 32'h44);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv[6:0], 7'h61);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'h61);
    xfer(`ULS_OFS_DATA, 0, 0);
    // A long break must still store a single entry
    rx_line <= 0; repeat (30) @(posedge hclk);
    rx_line <= 1; @(posedge hclk);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'hf9);
    xfer(`ULS_OFS_DATA, 0, 0); chk(rv, 32'h0);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv[6:0], 7'h60);
    // Status read in the very next cycle must already see the character
    rx_char_valid <= 1; rx_d <= 8'h66; rx_pe <= 0; rx_fe <= 0;
    @(posedge hclk);
    rx_char_valid <= 0;
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'h61);
    xfer(`ULS_OFS_DATA, 0, 0); chk(rv, 32'h66);
    // Reset in mid-run with an erroneous character queued
    rxc(8'h77, 1, 1);
    hresetn <= 0;
    @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    chk(irq, 0);
    xfer(`ULS_OFS_LSTAT, 0, 0); chk(rv, 32'h60);
    xfer(`ULS_OFS_DATA, 0, 0); chk(rv, 32'h0);
    finish_test;
  end
endmodule // test_uls_line_status

// File: test/uls_line_status_properties.sv
`timescale 1ns/1ps
`include "uls_defines.vh"
module uls_line_status_properties #(
  parameter FRAME_CYCLES = 8
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Line side
  input wire logic        rx_char_valid,
  input wire logic        tx_shift_busy,
  input wire logic        tx_load,
  input wire logic [7:0]  tx_data
);
  wire rd_any  = hsel && htrans[1] && hready && !hwrite;
  wire rd_lstat = rd_any && (haddr[7:0] == `ULS_OFS_LSTAT);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  a_load_pulse: assert property (tx_load |=> !tx_load)
    else $error("load longer than one cycle");
  a_load_gap: assert property (tx_shift_busy |=> !tx_load)
    else $error("load while shifter busy");
  a_data_hold: assert property ($changed(tx_data) |-> tx_load)
    else $error("tx data moved without load");
  a_idle_rdata: assert property (!rd_any |=> hrdata == 32'h0)
    else $error("read data outside read");
  a_temt_busy: assert property
    (rd_lstat && tx_shift_busy |=> !hrdata[6])
    else $error("empty flag while shifting");
  a_rx_ready: assert property
    (rx_char_valid ##1 rd_lstat |=> hrdata[0])
    else $error("data ready missing");
  a_lstat_width: assert property (rd_lstat |=> hrdata[31:8] == 24'h0)
    else $error("status upper bits set");
endmodule // uls_line_status_properties
bind uls_line_status uls_line_status_properties #(
  .FRAME_CYCLES(FRAME_CYCLES)
) i_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .rx_char_valid(rx_char_valid),
  .tx_shift_busy(tx_shift_busy), .tx_load(tx_load), .tx_data(tx_data)
);

// File: test/uls_tx_shifter.sv
`timescale 1ns/1ps
module uls_tx_shifter #(
  parameter SHIFT_CYCLES = 20
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Load handshake
  input  wire logic tx_load,
  output logic      tx_shift_busy
);
  logic [7:0] cnt_r;
  // Busy rises the cycle after a load, as the device expects
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r         <= 8'h00;
      tx_shift_busy <= 1'b0;
    end
    else if (tx_load)
    begin
      cnt_r         <= 8'(SHIFT_CYCLES);
      tx_shift_busy <= 1'b1;
    end
    else if (cnt_r > 8'h01)
      cnt_r <= cnt_r - 8'h01;
    else
    begin
      cnt_r         <= 8'h00;
      tx_shift_busy <= 1'b0;
    end
  end
endmodule // uls_tx_shifter
